// File: rtl/jump_and_increment_exec.sv
`timescale 1ns/1ps
module jump_and_increment_exec
    import jump_exec_pkg::*;
(
    input  wire logic               clk,          // Instruction clock.
    input  wire logic               sys_rst,      // Sync reset, high.
    input  wire logic               instr_valid,  // Word on instr_word.
    input  wire logic [INSTR_W-1:0] instr_word,   // Fetched instruction.
    input  wire logic [DATA_W-1:0]  file_rdata,   // Addressed register.
    input  wire logic [DATA_W-1:0]  status_reg,   // Status register.
    output pc_load_t                pc_out,       // Counter load.
    output acc_wr_t                 acc_out,      // Accumulator write.
    output file_wr_t                file_out,     // File write.
    output flag_wr_t                zero_out,     // Zero flag update.
    output logic                    slot_discard  // Fetched word dropped.
);

    // Sequencer state and its next value.
    exec_state_t state_ff;
    exec_state_t nxt_state;

    // Registered outputs and their next values.
    pc_load_t pc_ff;
    pc_load_t nxt_pc;
    acc_wr_t  acc_ff;
    acc_wr_t  nxt_acc;
    file_wr_t file_ff;
    file_wr_t nxt_file;
    flag_wr_t zero_ff;
    flag_wr_t nxt_zero;
    logic     discard_ff;
    logic     nxt_discard;

    // Decode of the word on offer.
    op_kind_t          op_kind;    // Class of the incoming word.
    logic              can_take;   // Sequencer accepts a word now.
    logic              take_jump;  // A jump is taken this edge.
    logic              take_inc;   // A plain increment is taken.
    logic              take_skip;  // An increment-skip is taken.
    logic              dest_file;  // Destination bit d.
    logic [DATA_W-1:0] inc_res;    // Incremented operand.
    logic              inc_zero;   // Incremented value is zero.

    // Shared incrementer for both increment forms.
    incr_unit u_incr (
        .operand (file_rdata),
        .result  (inc_res),
        .is_zero (inc_zero)
    );

    // Decode is combinational; words offered in the flush slot are
    // never classed as taken, which keeps the checks honest.
    always_comb begin
        op_kind   = decode_op(instr_word);
        can_take  = instr_valid && (state_ff == ST_EXEC);
        take_jump = can_take && (op_kind == OP_JUMP);
        take_inc  = can_take && (op_kind == OP_INC);
        take_skip = can_take && (op_kind == OP_INC_SKIP);
        dest_file = instr_word[DEST_BIT];
    end

    // Next-value logic for the sequencer and every output register.
    // Strobes default low so each one lasts exactly one cycle.
    always_comb begin
        nxt_state   = ST_EXEC;
        nxt_pc      = '{load: 1'b0, target: pc_ff.target};
        nxt_acc     = '{we: 1'b0, data: acc_ff.data};
        nxt_file    = '{we: 1'b0, addr: file_ff.addr, data: file_ff.data};
        nxt_zero    = '{we: 1'b0, val: zero_ff.val};
        nxt_discard = 1'b0;
        case (state_ff)
            ST_FLUSH: begin
                // The prefetched word is dropped whatever it is; this
                // slot executes as a no-operation.
                nxt_discard = 1'b1;
            end
            ST_EXEC: begin
                if (take_jump) begin
                    // Page bits fill the top of the counter and the
                    // literal the rest; both land in one load.
                    nxt_pc.load                 = 1'b1;
                    nxt_pc.target[PC_W-1:LIT_W] =
                        status_reg[PAGE_HI_BIT:PAGE_LO_BIT];
                    nxt_pc.target[LIT_W-1:0]    =
                        instr_word[LIT_W-1:0];
                    // Second cycle flushes the prefetch; no flag is touched.
                    nxt_state = ST_FLUSH;
                end else if (take_inc || take_skip) begin
                    // Result goes to the file when d is set, else to the
                    // accumulator.
                    if (dest_file) begin
                        nxt_file.we   = 1'b1;
                        nxt_file.addr = instr_word[FADDR_W-1:0];
                        nxt_file.data = inc_res;
                    end else begin
                        nxt_acc.we   = 1'b1;
                        nxt_acc.data = inc_res;
                    end
                    if (take_inc) begin
                        // One cycle, zero flag follows the wrapped result.
                        nxt_zero.we  = 1'b1;
                        nxt_zero.val = inc_zero;
                    end else if (inc_zero) begin
                        // Skip form leaves flags alone and may cost a
                        // cycle.
                        nxt_state = ST_FLUSH;
                    end
                end
            end
        endcase
    end

    // Registers only; reset clears all strobes and the sequencer.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff   <= ST_EXEC;
            pc_ff      <= '{load: 1'b0, target: RST_PC};
            acc_ff     <= '{we: 1'b0, data: RST_DATA};
            file_ff    <= '{we: 1'b0, addr: RST_ADDR, data: RST_DATA};
            zero_ff    <= '{we: 1'b0, val: 1'b0};
            discard_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            pc_ff      <= nxt_pc;
            acc_ff     <= nxt_acc;
            file_ff    <= nxt_file;
            zero_ff    <= nxt_zero;
            discard_ff <= nxt_discard;
        end
    end

    // Outputs come straight from the registers.
    assign pc_out       = pc_ff;
    assign acc_out      = acc_ff;
    assign file_out     = file_ff;
    assign zero_out     = zero_ff;
    assign slot_discard = discard_ff;

    // Two-cycle tail: flush state, then the discard strobe.
    sequence s_flush_tail;
        (state_ff == ST_FLUSH) && !slot_discard
        ##1 slot_discard && (state_ff == ST_EXEC);
    endsequence

    // The jump target low bits match the literal.
    property p_jump_low;
        @(posedge clk) disable iff (sys_rst)
        take_jump |=> pc_out.load &&
            (pc_out.target[LIT_W-1:0] == $past(instr_word[LIT_W-1:0]));
    endproperty
    a_jump_low: assert property (p_jump_low)
        else $error("jump target low bits wrong");

    // The jump target page bits match the status bits.
    property p_jump_page;
        @(posedge clk) disable iff (sys_rst)
        take_jump |=> pc_out.target[PC_W-1:LIT_W] ==
            $past(status_reg[PAGE_HI_BIT:PAGE_LO_BIT]);
    endproperty
    a_jump_page: assert property (p_jump_page)
        else $error("jump page bits wrong");

    // A jump takes two cycles and writes nothing else.
    property p_jump_two;
        @(posedge clk) disable iff (sys_rst)
        take_jump |=> !zero_out.we && !acc_out.we && !file_out.we
            ##0 s_flush_tail;
    endproperty
    a_jump_two: assert property (p_jump_two)
        else $error("jump timing or side effect wrong");

    // Destination follows d for both increment forms.
    property p_inc_dest;
        @(posedge clk) disable iff (sys_rst)
        (take_inc || take_skip) |=>
            (file_out.we == $past(dest_file)) &&
            (acc_out.we == !$past(dest_file)) && !pc_out.load;
    endproperty
    a_inc_dest: assert property (p_inc_dest)
        else $error("increment destination wrong");

    // Plain increment is single cycle and updates zero.
    property p_inc_zero;
        @(posedge clk) disable iff (sys_rst)
        take_inc |=> zero_out.we && (state_ff == ST_EXEC) &&
            (zero_out.val == ($past(file_rdata) == ALL_ONES));
    endproperty
    a_inc_zero: assert property (p_inc_zero)
        else $error("increment zero flag wrong");

    // Increment-skip never touches the zero flag, nor does the slot
    // that it drops; a word run in that slot may still do so.
    property p_skip_flags;
        @(posedge clk) disable iff (sys_rst)
        take_skip |=> !zero_out.we ##1 (!slot_discard || !zero_out.we);
    endproperty
    a_skip_flags: assert property (p_skip_flags)
        else $error("skip form changed a flag");

    // A zero skip result drops the next word; otherwise no drop.
    property p_skip_zero;
        @(posedge clk) disable iff (sys_rst)
        take_skip |=> ((state_ff == ST_FLUSH) ==
            ($past(file_rdata) == ALL_ONES)) ##1
            (slot_discard == ($past(file_rdata, 2) == ALL_ONES));
    endproperty
    a_skip_zero: assert property (p_skip_zero)
        else $error("skip discard wrong");

    // The result wraps to zero from all ones.
    property p_wrap;
        @(posedge clk) disable iff (sys_rst)
        (take_inc || take_skip) && (file_rdata == ALL_ONES) |=>
            (file_out.we ? file_out.data : acc_out.data) == RST_DATA;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("increment did not wrap");

    // Reset leaves every strobe low and the sequencer idle, so a
    // reset in a flush slot cannot leak a drop past it.
    property p_rst_clear;
        @(posedge clk)
        sys_rst |=> !pc_out.load && !acc_out.we && !file_out.we &&
            !zero_out.we && !slot_discard && (state_ff == ST_EXEC);
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("reset left a strobe high");

endmodule // jump_and_increment_exec

// File: rtl/jump_exec_pkg.sv
// Shared constants and carriers for the jump and increment execute block.
package jump_exec_pkg;

    // Instruction word layout.
    localparam int INSTR_W      = 12;         // Width of one program word.
    localparam int DATA_W       = 8;          // Width of the data path.
    localparam int FADDR_W      = 5;          // Width of a file address.
    localparam int PC_W         = 11;         // Width of the program counter.
    localparam int LIT_W        = 9;          // Width of the jump literal.
    localparam int DEST_BIT     = 5;          // Destination select bit d.
    localparam int PAGE_LO_BIT  = 5;          // Low page bit in status.
    localparam int PAGE_HI_BIT  = 6;          // High page bit in status.

    // Opcode patterns, compared against the top bits of the word.
    localparam logic [2:0] OPC_JUMP      = 3'h5;    // Top three bits 101.
    localparam logic [5:0] OPC_INC       = 6'h0A;   // 0010 10 prefix.
    localparam logic [5:0] OPC_INC_SKIP  = 6'h0F;   // 0011 11 prefix.

    // Values after reset.
    localparam logic [PC_W-1:0]    RST_PC   = 11'h000; // Cleared target.
    localparam logic [DATA_W-1:0]  RST_DATA = 8'h00;   // Cleared data.
    localparam logic [FADDR_W-1:0] RST_ADDR = 5'h00;   // Cleared address.
    localparam logic [DATA_W-1:0]  ALL_ONES = 8'hFF;   // Value that wraps.

    // Decoded operation class.
    typedef enum logic [1:0] {
        OP_NONE      = 2'b00,
        OP_JUMP      = 2'b01,
        OP_INC       = 2'b11,
        OP_INC_SKIP  = 2'b10
    } op_kind_t;

    // Execute sequencer states, Gray coded.
    typedef enum logic {
        ST_EXEC  = 1'b0,
        ST_FLUSH = 1'b1
    } exec_state_t;

    // Program counter load request.
    typedef struct packed {
        logic            load;    // One-cycle load strobe.
        logic [PC_W-1:0] target;  // New counter value.
    } pc_load_t;

    // Accumulator write request.
    typedef struct packed {
        logic              we;    // One-cycle write strobe.
        logic [DATA_W-1:0] data;  // Value to write.
    } acc_wr_t;

    // File register write request.
    typedef struct packed {
        logic               we;   // One-cycle write strobe.
        logic [FADDR_W-1:0] addr; // Register address.
        logic [DATA_W-1:0]  data; // Value to write.
    } file_wr_t;

    // Zero flag update request.
    typedef struct packed {
        logic we;                 // One-cycle update strobe.
        logic val;                // New flag value.
    } flag_wr_t;

    // Classifies an instruction word; called only by the decode.
    function automatic op_kind_t decode_op(input logic [INSTR_W-1:0] w);
        if (w[11:9] == OPC_JUMP) begin
            return OP_JUMP;
        end else if (w[11:6] == OPC_INC) begin
            return OP_INC;
        end else if (w[11:6] == OPC_INC_SKIP) begin
            return OP_INC_SKIP;
        end else begin
            return OP_NONE;
        end
    endfunction

endpackage

// File: rtl/incr_unit.sv
`timescale 1ns/1ps
// Eight-bit incrementer with zero detect; purely combinational.
module incr_unit
    import jump_exec_pkg::*;
(
    input  wire logic [DATA_W-1:0] operand,  // Value read from the file.
    output logic      [DATA_W-1:0] result,   // Operand plus one.
    output logic                   is_zero   // High when result is zero.
);

    // The carry out is dropped on purpose so the count wraps at 256.
    always_comb begin
        result  = DATA_W'(operand + 8'h01);
        is_zero = (result == RST_DATA);
    end

endmodule // incr_unit

// File: sim/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the jump and increment execute block.
module tb_top
    import jump_exec_pkg::*;
;

    // One table row: stimulus beside the strobes that it should give.
    typedef struct {
        logic [11:0] w;
        logic [7:0]  rd, st;
        logic        ld;
        logic [10:0] tg;
        logic        aw, fw;
        logic [7:0]  dt;
        logic        zw, zv, ds;
    } row_t;

    logic               clk;          // Instruction clock.
    logic               sys_rst;      // Synchronous reset.
    logic               instr_valid;  // Word offered.
    logic [INSTR_W-1:0] instr_word;   // Offered word.
    logic [DATA_W-1:0]  file_rdata;   // Addressed register content.
    logic [DATA_W-1:0]  status_reg;   // Page bits live in 6:5.
    pc_load_t           pc_out;       // Counter load request.
    acc_wr_t            acc_out;      // Accumulator write request.
    file_wr_t           file_out;     // File write request.
    flag_wr_t           zero_out;     // Zero flag request.
    logic               slot_discard; // Dropped slot marker.
    int                 num_errors;   // Mismatches seen.
    int                 checked;      // Comparisons made.

    // Jumps on page values 11, 01 and 10, both increments both ways, wrap, other op.
    row_t rows [9] = '{
        '{12'hA5A, 8'h00, 8'h60, 1, 11'h65A, 0, 0, 8'h00, 0, 0, 1},
        '{12'hA00, 8'h00, 8'h20, 1, 11'h200, 0, 0, 8'h00, 0, 0, 1},
        '{12'hBFF, 8'h00, 8'h5F, 1, 11'h5FF, 0, 0, 8'h00, 0, 0, 1},
        '{12'h283, 8'h41, 8'h00, 0, 11'h000, 1, 0, 8'h42, 1, 0, 0},
        '{12'h2A7, 8'hFF, 8'h00, 0, 11'h000, 0, 1, 8'h00, 1, 1, 0},
        '{12'h3C1, 8'h10, 8'h00, 0, 11'h000, 1, 0, 8'h11, 0, 0, 0},
        '{12'h3FF, 8'hFF, 8'h00, 0, 11'h000, 0, 1, 8'h00, 0, 0, 1},
        '{12'h3C4, 8'hFF, 8'h00, 0, 11'h000, 1, 0, 8'h00, 0, 0, 1},
        '{12'h250, 8'h33, 8'h60, 0, 11'h000, 0, 0, 8'h00, 0, 0, 0}
    };

    jump_and_increment_exec i_dut (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .instr_valid  (instr_valid),
        .instr_word   (instr_word),
        .file_rdata   (file_rdata),
        .status_reg   (status_reg),
        .pc_out       (pc_out),
        .acc_out      (acc_out),
        .file_out     (file_out),
        .zero_out     (zero_out),
        .slot_discard (slot_discard)
    );

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compares one value; case inequality so an unknown never matches.
    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    // Drives one cycle at a rising edge, then waits for settled outputs.
    task automatic put(input logic v, input logic [11:0] w,
                       input logic [7:0] rd, input logic [7:0] st);
        @(posedge clk);
        instr_valid <= v;
        instr_word  <= w;
        file_rdata  <= rd;
        status_reg  <= st;
        @(negedge clk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The whole run should take well under a hundred cycles.
    initial begin
        #20000;
        num_errors++;
        results();
    end

    initial begin
        num_errors = 0;
        checked = 0;
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = '0;
        file_rdata = '0;
        status_reg = '0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk("rst_strobes", {pc_out.load, acc_out.we, file_out.we}, 0);
        chk("rst_data", {acc_out.data, file_out.data}, 0);
        chk("rst_tgt", {pc_out.target, file_out.addr}, 0);
        put(0, 12'h000, 8'h00, 8'h00);
        chk("rel_strobes", {zero_out.we, slot_discard, pc_out.load}, 0);
        // Ordinary cases, one word each, with idle cycles after it.
        foreach (rows[i]) begin
            put(1, rows[i].w, rows[i].rd, rows[i].st);
            put(0, 12'h000, 8'h00, 8'h00);
            chk("pc_load", pc_out.load, rows[i].ld);
            if (rows[i].ld)
                chk("target", pc_out.target, rows[i].tg);
            chk("acc_we", acc_out.we, rows[i].aw);
            chk("file_we", file_out.we, rows[i].fw);
            if (rows[i].aw)
                chk("acc", acc_out.data, rows[i].dt);
            if (rows[i].fw) chk("file", {file_out.addr, file_out.data},
                {rows[i].w[4:0], rows[i].dt});
            chk("zero_we", zero_out.we, rows[i].zw);
            if (rows[i].zw)
                chk("zero", zero_out.val, rows[i].zv);
            put(0, 12'h000, 8'h00, 8'h00);
            chk("discard", slot_discard, rows[i].ds);
        end
        // A valid word in the slot after a jump is dropped, then refetched.
        put(1, 12'hA12, 8'h00, 8'h00);
        put(1, 12'h280, 8'h05, 8'h00);
        chk("jmp_ld", pc_out.load, 1);
        chk("jmp_flag", zero_out.we, 0);
        put(1, 12'h280, 8'h05, 8'h00);
        chk("slot_acc", acc_out.we, 0);
        chk("slot_mark", slot_discard, 1);
        put(0, 12'h000, 8'h00, 8'h00);
        chk("refetch", {acc_out.we, acc_out.data}, 16'h0106);
        // A non-zero skip lets the next word run back to back.
        put(1, 12'h3E2, 8'h7F, 8'h00);
        put(1, 12'h289, 8'h09, 8'h00);
        chk("skip_wr", {file_out.we, file_out.data}, 16'h0180);
        chk("skip_flag", zero_out.we, 0);
        put(0, 12'h000, 8'h00, 8'h00);
        chk("next_acc", {acc_out.we, acc_out.data}, 16'h010A);
        chk("next_zero", {zero_out.we, zero_out.val}, 16'h0002);
        chk("no_drop", slot_discard, 0);
        // A zero skip drops a jump sitting in its slot.
        put(1, 12'h3C0, 8'hFF, 8'h00);
        put(1, 12'hA77, 8'h00, 8'h60);
        chk("wrap_acc", {acc_out.we, acc_out.data}, 16'h0100);
        put(0, 12'h000, 8'h00, 8'h00);
        chk("drop_jump", pc_out.load, 0);
        chk("drop_mark", slot_discard, 1);
        // Reset in the slot after a jump clears the pending drop and the
        // target; the first word after release is taken normally.
        put(1, 12'hA12, 8'h00, 8'h00);
        @(posedge clk);
        sys_rst     <= 1'b1;
        instr_valid <= 1'b0;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk("mid_rst", {pc_out.target, slot_discard}, 0);
        put(1, 12'h280, 8'h05, 8'h00);
        put(0, 12'h000, 8'h00, 8'h00);
        chk("rst_take", {acc_out.we, acc_out.data}, 16'h0106);
        chk("rst_drop", slot_discard, 0);
        put(0, 12'h000, 8'h00, 8'h00);
        results();
    end
endmodule // tb_top
